// File: rtl/rmcl_defs.vh
// register map common logic: offsets, field positions, reset values
// assumes a 9-bit host address, 16-bit data and an 8-bit/16-bit bus mode pin
`ifndef RMCL_DEFS_VH
`define RMCL_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (16-bit word addresses, 8-bit mode uses bit 0 as lane)
// ----------------------------------------------------------------------
`define RMCL_OFS_DEVICE_IDENTIFICATION 9'h000
`define RMCL_OFS_GLOBAL_CONTROL_ONE 9'h002
`define RMCL_OFS_GLOBAL_CONTROL_TWO 9'h004
`define RMCL_OFS_GENERAL_PIN_CONTROL 9'h00A
`define RMCL_OFS_STATUS 9'h014
`define RMCL_OFS_STATUS_LATCHED 9'h016
`define RMCL_OFS_COUNT 9'h01A
`define RMCL_OFS_MODE_STATUS_LATCHED 9'h01C

// ----------------------------------------------------------------------
// global control one fields
// ----------------------------------------------------------------------
`define RMCL_CR1_SNAPSHOT_BIT 3
`define RMCL_CR1_CLEAR_SELECT_BIT 2
`define RMCL_CR1_MASK 16'h40FF

// ----------------------------------------------------------------------
// reset values and the cr2 write mask
// ----------------------------------------------------------------------
`define RMCL_CR1_RESET 16'h0000
`define RMCL_CR2_RESET 16'h0000
`define RMCL_GIOCR_RESET 16'h0000
`define RMCL_CR2_MASK 16'h0F0E

// ----------------------------------------------------------------------
// block address ranges: low and high inclusive
// ----------------------------------------------------------------------
`define RMCL_GLB_LO 9'h000
`define RMCL_GLB_HI 9'h01F
`define RMCL_PORT_LO 9'h040
`define RMCL_PORT_HI 9'h05F
`define RMCL_BERT_LO 9'h060
`define RMCL_BERT_HI 9'h07F
`define RMCL_LENC_LO 9'h08C
`define RMCL_LENC_HI 9'h08F
`define RMCL_LDEC_LO 9'h090
`define RMCL_LDEC_HI 9'h0DF
`define RMCL_TT_LO 9'h0E8
`define RMCL_TT_HI 9'h0FF
`define RMCL_FRM_LO 9'h118
`define RMCL_FRM_HI 9'h13F
`define RMCL_TEST_LO 9'h180
`define RMCL_TEST_HI 9'h19F

`endif

// File: rtl/rmcl_top.v
// register map common logic: host register port, latched status, counter
// assumes host strobes are synchronous to clock_i; events come from same-clock logic
`timescale 1ns/1ps
`include "rmcl_defs.vh"

module rmcl_top #(
    parameter CNT_W = 16,
    parameter [15:0] ID_VALUE = 16'h0A5C // arbitrary identification value
) (
    // clock and resets
    input wire clock_i,
    input wire rst_b_i,
    input wire datapath_reset_n_i,
    // host register port
    input wire [8:0] addr_i,
    input wire [15:0] wdata_i,
    input wire rd_i,
    input wire wr_i,
    input wire bus8_i,
    output reg [15:0] rdata_o,
    output reg ready_n_o,
    // events and mode from the data path
    input wire [7:0] event_i,
    input wire [7:0] mode_active_i,
    input wire count_event_i,
    input wire [7:0] irq_enable_i,
    // outputs to the data path
    output reg [15:0] cr2_o,
    output reg [15:0] pin_ctrl_o,
    output reg zero_count_n_o,
    output reg irq_o
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function in_block;
        input [8:0] a;
        begin
            in_block = (a <= `RMCL_GLB_HI) ||
                (a >= `RMCL_PORT_LO && a <= `RMCL_BERT_HI) ||
                (a >= `RMCL_LENC_LO && a <= `RMCL_LDEC_HI) ||
                (a >= `RMCL_TT_LO && a <= `RMCL_TT_HI) ||
                (a >= `RMCL_FRM_LO && a <= `RMCL_FRM_HI) ||
                (a >= `RMCL_TEST_LO && a <= `RMCL_TEST_HI);
        end
    endfunction

    // byte-lane merge: a lane that is not written keeps its stored bits
    function [15:0] lane_merge;
        input [15:0] old_val;
        input [15:0] new_val;
        input hi_en;
        input lo_en;
        begin
            lane_merge = old_val;
            if (hi_en)
                lane_merge[15:8] = new_val[15:8];
            if (lo_en)
                lane_merge[7:0] = new_val[7:0];
        end
    endfunction

    // bits one host access clears in a latched register this cycle
    function [7:0] clear_pattern;
        input wr_clear;
        input rd_sel;
        input wr_sel;
        input [7:0] wr_bits;
        begin
            if (!wr_clear && rd_sel)
                clear_pattern = 8'hFF;
            else if (wr_clear && wr_sel)
                clear_pattern = wr_bits;
            else
                clear_pattern = 8'h00;
        end
    endfunction

    // a full counter holds its value rather than wrapping back to zero
    function [CNT_W-1:0] sat_inc;
        input [CNT_W-1:0] cnt;
        begin
            if (&cnt)
                sat_inc = cnt;
            else
                sat_inc = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // 8-bit mode hands back one byte in the low lane
    function [15:0] lane_select;
        input [15:0] word;
        input narrow;
        input odd;
        begin
            if (!narrow)
                lane_select = word;
            else if (odd)
                lane_select = {8'h00, word[15:8]};
            else
                lane_select = {8'h00, word[7:0]};
        end
    endfunction

    // in 8-bit mode bit 0 picks the lane, so the word address drops it
    wire [8:0] word_addr = {addr_i[8:1], 1'b0};
    wire hit_block = in_block(addr_i);
    wire wr_hi = wr_i && (!bus8_i || addr_i[0]);
    wire wr_lo = wr_i && (!bus8_i || !addr_i[0]);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [15:0] cr1_r;
    reg [15:0] cr2_r;
    reg [15:0] pin_r;
    reg [7:0] latched_r;
    reg [7:0] mode_latched_r;
    reg [7:0] event_d_r;
    reg [CNT_W-1:0] run_cnt_r;
    reg [CNT_W-1:0] cnt_reg_r;
    reg snap_d_r;
    reg done_r;
    reg [1:0] upd_state_r;

    localparam [1:0] UPD_IDLE = 2'h0;
    localparam [1:0] UPD_COPY = 2'h1;
    localparam [1:0] UPD_DONE = 2'h2;

    wire dp_rst = !datapath_reset_n_i;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // reserved cr1 and cr2 bits are masked off on write, so software reads them back as zero
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cr1_r <= `RMCL_CR1_RESET;
            cr2_r <= `RMCL_CR2_RESET;
            pin_r <= `RMCL_GIOCR_RESET;
        end else if (wr_i) begin
            if (word_addr == `RMCL_OFS_GLOBAL_CONTROL_ONE)
                cr1_r <= lane_merge(cr1_r, wdata_i & `RMCL_CR1_MASK, wr_hi, wr_lo);
            if (word_addr == `RMCL_OFS_GLOBAL_CONTROL_TWO)
                cr2_r <= lane_merge(cr2_r, wdata_i & `RMCL_CR2_MASK, wr_hi, wr_lo);
            if (word_addr == `RMCL_OFS_GENERAL_PIN_CONTROL)
                pin_r <= lane_merge(pin_r, wdata_i, wr_hi, wr_lo);
        end
    end

    // data path copies only follow the registers outside data path reset
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cr2_o <= `RMCL_CR2_RESET;
            pin_ctrl_o <= `RMCL_GIOCR_RESET;
        end else if (!dp_rst) begin
            cr2_o <= cr2_r;
            pin_ctrl_o <= pin_r;
        end
    end

    // ------------------------------------------------------------------
    // latched status
    // ------------------------------------------------------------------
    wire clear_on_write = cr1_r[`RMCL_CR1_CLEAR_SELECT_BIT];
    wire rd_lat = rd_i && word_addr == `RMCL_OFS_STATUS_LATCHED;
    wire wr_lat = wr_i && word_addr == `RMCL_OFS_STATUS_LATCHED;
    wire rd_mlat = rd_i && word_addr == `RMCL_OFS_MODE_STATUS_LATCHED;
    wire wr_mlat = wr_i && word_addr == `RMCL_OFS_MODE_STATUS_LATCHED;
    // both latched registers live in the low byte; upper lane holds nothing
    wire rd_lo_lane = !bus8_i || !addr_i[0];
    wire [7:0] ev_on = event_i & ~event_d_r & mode_active_i;
    wire [7:0] ev_chg = (event_i ^ event_d_r) & mode_active_i;
    wire [7:0] clr_lat = clear_pattern(clear_on_write, rd_lat && rd_lo_lane, wr_lat && wr_lo, wdata_i[7:0]);
    wire [7:0] clr_mlat = clear_pattern(clear_on_write, rd_mlat && rd_lo_lane, wr_mlat && wr_lo, wdata_i[7:0]);
    // a new event wins over a clear in the same cycle
    wire [7:0] latched_nxt = (latched_r & ~clr_lat) | ev_on;
    wire [7:0] mode_latched_nxt = (mode_latched_r & ~clr_mlat) | ev_chg;

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            event_d_r <= 8'h00;
            latched_r <= 8'h00;
            mode_latched_r <= 8'h00;
        end else begin
            event_d_r <= event_i;
            if (dp_rst) begin
                latched_r <= 8'h00;
                mode_latched_r <= 8'h00;
            end else begin
                latched_r <= latched_nxt;
                mode_latched_r <= mode_latched_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // counter and snapshot
    // ------------------------------------------------------------------
    wire snap_req = cr1_r[`RMCL_CR1_SNAPSHOT_BIT];
    wire snap_rise = snap_req && !snap_d_r && !dp_rst;
    // counter slot 0 is a reserved counter when bit 0 of mode is low
    wire cnt_live = count_event_i && mode_active_i[0];
    wire [CNT_W-1:0] cnt_inc = sat_inc(run_cnt_r);

    // update sequencer: a snapshot request seen mid-update is dropped, so the
    // host must wait for done before it asks again
    reg [1:0] upd_state_nxt;
    always @* begin
        upd_state_nxt = upd_state_r;
        case (upd_state_r)
            UPD_IDLE: begin
                if (snap_rise)
                    upd_state_nxt = UPD_COPY;
            end
            UPD_COPY: begin
                upd_state_nxt = UPD_DONE;
            end
            UPD_DONE: begin
                upd_state_nxt = UPD_IDLE;
            end
            default: begin
                upd_state_nxt = UPD_IDLE;
            end
        endcase
    end

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            snap_d_r <= 1'b0;
            done_r <= 1'b1;
            upd_state_r <= UPD_IDLE;
            run_cnt_r <= {CNT_W{1'b0}};
            cnt_reg_r <= {CNT_W{1'b0}};
            zero_count_n_o <= 1'b1;
        end else begin
            snap_d_r <= snap_req;
            zero_count_n_o <= 1'b1;
            if (dp_rst) begin
                run_cnt_r <= {CNT_W{1'b0}};
                cnt_reg_r <= {CNT_W{1'b0}};
                upd_state_r <= UPD_IDLE;
                done_r <= 1'b1;
            end else begin
                upd_state_r <= upd_state_nxt;
                case (upd_state_r)
                    UPD_IDLE: begin
                        if (cnt_live)
                            run_cnt_r <= cnt_inc;
                        if (snap_rise)
                            done_r <= 1'b0;
                    end
                    UPD_COPY: begin
                        cnt_reg_r <= run_cnt_r;
                        // an event on the copy edge starts the fresh count at one
                        run_cnt_r <= cnt_live ? {{(CNT_W-1){1'b0}}, 1'b1} : {CNT_W{1'b0}};
                        zero_count_n_o <= 1'b0;
                    end
                    UPD_DONE: begin
                        if (cnt_live)
                            run_cnt_r <= cnt_inc;
                        done_r <= 1'b1;
                    end
                    default: begin
                        done_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt: enables for reserved bits still count
    // ------------------------------------------------------------------
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i)
            irq_o <= 1'b0;
        else
            irq_o <= |((latched_r | mode_latched_r) & irq_enable_i);
    end

    // ------------------------------------------------------------------
    // read mux and ready
    // ------------------------------------------------------------------
    // snapshot done is ORed onto bit 1 with live event 1; bit 0 and unused modes read zero
    wire [15:0] status_word = {8'h00, event_i & mode_active_i & 8'hFE} | {14'h0000, done_r, 1'b0};
    // zero-extend first so any counter width down to one bit reads cleanly
    wire [CNT_W+15:0] cnt_wide = {16'h0000, cnt_reg_r};
    wire acc_hit = (rd_i || wr_i) && hit_block;
    wire rd_hit = rd_i && hit_block;

    reg [15:0] word_rd;
    always @* begin
        word_rd = 16'h0000;
        case (word_addr)
            `RMCL_OFS_DEVICE_IDENTIFICATION: word_rd = ID_VALUE;
            `RMCL_OFS_GLOBAL_CONTROL_ONE: word_rd = cr1_r;
            `RMCL_OFS_GLOBAL_CONTROL_TWO: word_rd = cr2_r;
            `RMCL_OFS_GENERAL_PIN_CONTROL: word_rd = pin_r;
            `RMCL_OFS_STATUS: word_rd = status_word;
            `RMCL_OFS_STATUS_LATCHED: word_rd = {8'h00, latched_r};
            `RMCL_OFS_MODE_STATUS_LATCHED: word_rd = {8'h00, mode_latched_r};
            `RMCL_OFS_COUNT: word_rd = cnt_wide[15:0];
            default: word_rd = 16'h0000;
        endcase
    end

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 16'h0000;
            ready_n_o <= 1'b1;
        end else begin
            ready_n_o <= !acc_hit;
            if (rd_hit)
                rdata_o <= lane_select(word_rd, bus8_i, addr_i[0]);
            else
                rdata_o <= 16'h0000;
        end
    end

endmodule // rmcl_top

// File: tb/rmcl_checker.sv
// checker: register port timing, snapshot pulse and data path reset hold
// assumes host strobes are single-cycle pulses sampled on clock_i
`timescale 1ns/1ps
`include "rmcl_defs.vh"
module rmcl_checker #(
    parameter CNT_W = 16,
    parameter [15:0] ID_VALUE = 16'h0A5C // arbitrary identification value
) (
    // clock and resets
    input logic clock_i,
    input logic rst_b_i,
    input logic datapath_reset_n_i,
    // register port
    input logic [8:0] addr_i,
    input logic [15:0] wdata_i,
    input logic rd_i,
    input logic wr_i,
    input logic [15:0] rdata_o,
    input logic ready_n_o,
    // data path side
    input logic [15:0] cr2_o,
    input logic [15:0] pin_ctrl_o,
    input logic zero_count_n_o,
    input logic irq_o
);
    // ------------
    // helpers
    // ------------
    wire acc = rd_i | wr_i;
    wire in_blk = (addr_i <= `RMCL_GLB_HI) || (addr_i >= `RMCL_PORT_LO && addr_i <= `RMCL_BERT_HI)
        || (addr_i >= `RMCL_LENC_LO && addr_i <= `RMCL_LDEC_HI) || (addr_i >= `RMCL_TT_LO && addr_i <= `RMCL_TT_HI)
        || (addr_i >= `RMCL_FRM_LO && addr_i <= `RMCL_FRM_HI) || (addr_i >= `RMCL_TEST_LO && addr_i <= `RMCL_TEST_HI);
    // shadow of the snapshot request bit, so only a zero-to-one write counts
    logic snap_bit_r;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            snap_bit_r <= 1'b0;
        end else if (wr_i && addr_i == `RMCL_OFS_GLOBAL_CONTROL_ONE) begin
            snap_bit_r <= wdata_i[`RMCL_CR1_SNAPSHOT_BIT];
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_acc_in;
        acc && in_blk;
    endsequence
    sequence s_snap;
        wr_i && addr_i == `RMCL_OFS_GLOBAL_CONTROL_ONE && wdata_i[`RMCL_CR1_SNAPSHOT_BIT] && !snap_bit_r
            && datapath_reset_n_i;
    endsequence
    // three cycles so a write taken just before the reset has landed
    sequence s_dp_held;
        !datapath_reset_n_i [*3];
    endsequence
    // ------------
    // assertions
    // ------------
    ready_in_block_a: assert property (s_acc_in |=> !ready_n_o) else $error("no ready for in-block access");
    ready_outside_a: assert property (acc && !in_blk |=> ready_n_o) else $error("ready for unmapped access");
    ready_idle_a: assert property (!acc |=> ready_n_o) else $error("ready without access");
    unmapped_rdata_a: assert property (rd_i && !in_blk |=> rdata_o == 16'h0000) else $error("unmapped read not zero");
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("read data without read");
    snap_zero_a: assert property (s_snap |-> ##3 !zero_count_n_o) else $error("no zero pulse after snapshot");
    zero_single_a: assert property ($fell(zero_count_n_o) |=> zero_count_n_o) else $error("zero pulse too long");
    config_frozen_a:
        assert property (s_dp_held |-> $stable(cr2_o) && $stable(pin_ctrl_o)) else $error("config changed in reset");
    dp_irq_clear_a: assert property (s_dp_held |-> !irq_o) else $error("irq kept in data path reset");
endmodule // rmcl_checker

// File: tb/rmcl_host.sv
// host model: single-cycle read and write strobes on the register port
// assumes a free-running clock_i; expected results are queued in exp_q
`timescale 1ns/1ps
module rmcl_host (
    // clock
    input wire clock_i,
    // register port
    output reg [8:0] addr_o = 9'h000,
    output reg [15:0] wdata_o = 16'h0000,
    output reg rd_o = 1'b0,
    output reg wr_o = 1'b0,
    output reg bus8_o = 1'b0
);
    logic [16:0] exp_q[$];
    // m: address is mapped, so a ready and, for reads, data e are expected
    task acc(input logic w, input logic [8:0] a, input logic [15:0] d, input logic [15:0] e, input logic m);
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= d;
        rd_o <= !w;
        wr_o <= w;
        if (m) exp_q.push_back({!w, e});
        @(posedge clock_i);
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        // released lines flip so stale values never look like live ones
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    // a zero then a one, so the device always sees a fresh rising edge
    task restart(input logic [15:0] base);
        acc(1'b1, 9'h002, base, 16'h0000, 1'b1);
        acc(1'b1, 9'h002, base | 16'h0008, 16'h0000, 1'b1);
    endtask
endmodule // rmcl_host

// File: tb/rmcl_top_bench.sv
// testbench: register traffic, status latching, counter snapshots
// assumes rmcl_host drives the port and queues expected results
`timescale 1ns/1ps
`include "rmcl_defs.vh"
module rmcl_top_bench;
    localparam [15:0] ID = 16'h0A5C; // arbitrary identification value
    localparam [15:0] M2 = `RMCL_CR2_MASK;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic datapath_reset_n_i = 1'b1;
    logic [7:0] event_i = 8'h00;
    logic [7:0] mode_active_i = 8'hFF;
    logic count_event_i = 1'b0;
    logic [7:0] irq_enable_i = 8'h00;
    wire [8:0] addr;
    wire [15:0] wdata, rdata_o, cr2_o, pin_ctrl_o;
    wire rd, wr, bus8, ready_n_o, zero_count_n_o, irq_o;
    logic [16:0] e;
    logic [15:0] r;
    int n_errors = 0;
    int checks_done = 0;
    always #10 clock_i = ~clock_i;
    rmcl_host h (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .rd_o(rd), .wr_o(wr), .bus8_o(bus8));
    rmcl_top #(.CNT_W(4), .ID_VALUE(ID)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .datapath_reset_n_i(datapath_reset_n_i), .addr_i(addr), .wdata_i(wdata), .rd_i(rd), .wr_i(wr),
        .bus8_i(bus8), .rdata_o(rdata_o), .ready_n_o(ready_n_o), .event_i(event_i), .mode_active_i(mode_active_i),
        .count_event_i(count_event_i), .irq_enable_i(irq_enable_i), .cr2_o(cr2_o), .pin_ctrl_o(pin_ctrl_o),
        .zero_count_n_o(zero_count_n_o), .irq_o(irq_o));
    // ------------
    // checking
    // ------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task cy(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // bounded wait until every queued answer has appeared
    task drain;
        for (int i = 0; i < 20 && h.exp_q.size() != 0; i++) @(posedge clock_i);
        // let outputs launched on the last edge settle before anyone looks
        cy(1);
        if (h.exp_q.size() != 0) begin
            check(16'h0001, 16'h0000);
            finish_test();
        end
    endtask
    always @(posedge clock_i) begin
        if (rst_b_i === 1'b1 && ready_n_o === 1'b0) begin
            if (h.exp_q.size() == 0) check(16'h0001, 16'h0000);
            else begin
                e = h.exp_q.pop_front();
                if (e[16]) check(rdata_o, e[15:0]);
            end
        end
    end
    // ------------
    // scenarios
    // ------------
    initial begin
        void'($urandom(32'h62b175c5));
        cy(10);
        rst_b_i <= 1'b1;
        r = 16'($urandom);
        h.acc(1'b1, 9'h000, 16'hFFFF, 16'h0000, 1'b1);
        h.acc(1'b0, 9'h000, 16'h0000, ID, 1'b1);
        h.acc(1'b0, 9'h006, 16'h0000, 16'h0000, 1'b1);
        h.acc(1'b1, 9'h020, r, 16'h0000, 1'b0);
        h.acc(1'b0, 9'h1A0, 16'h0000, 16'h0000, 1'b0);
        h.acc(1'b0, 9'h08B, 16'h0000, 16'h0000, 1'b0);
        h.acc(1'b1, 9'h19F, 16'h0000, 16'h0000, 1'b1);
        h.acc(1'b1, 9'h004, r, 16'h0000, 1'b1);
        h.acc(1'b0, 9'h004, 16'h0000, r & M2, 1'b1);
        h.acc(1'b1, 9'h00A, ~r, 16'h0000, 1'b1);
        drain();
        check(cr2_o, r & M2);
        check(pin_ctrl_o, ~r);
        h.bus8_o <= 1'b1;
        h.acc(1'b0, 9'h001, 16'h0000, {8'h00, ID[15:8]}, 1'b1);
        h.acc(1'b0, 9'h000, 16'h0000, {8'h00, ID[7:0]}, 1'b1);
        h.bus8_o <= 1'b0;
        irq_enable_i <= 8'h04;
        event_i <= 8'h04;
        cy(3);
        check({15'h0000, irq_o}, 16'h0001);
        h.acc(1'b0, 9'h016, 16'h0000, 16'h0004, 1'b1);
        h.acc(1'b0, 9'h016, 16'h0000, 16'h0000, 1'b1);
        h.acc(1'b0, 9'h01C, 16'h0000, 16'h0004, 1'b1);
        event_i <= 8'h00;
        cy(3);
        h.acc(1'b0, 9'h01C, 16'h0000, 16'h0004, 1'b1);
        h.acc(1'b1, 9'h002, 16'h0004, 16'h0000, 1'b1);
        event_i <= 8'h04;
        cy(3);
        h.acc(1'b0, 9'h016, 16'h0000, 16'h0004, 1'b1);
        h.acc(1'b1, 9'h016, 16'h00FB, 16'h0000, 1'b1);
        h.acc(1'b0, 9'h016, 16'h0000, 16'h0004, 1'b1);
        h.acc(1'b1, 9'h016, 16'h0004, 16'h0000, 1'b1);
        h.acc(1'b0, 9'h016, 16'h0000, 16'h0000, 1'b1);
        event_i <= 8'h00;
        mode_active_i <= 8'hFB;
        cy(2);
        event_i <= 8'h04;
        cy(3);
        h.acc(1'b0, 9'h016, 16'h0000, 16'h0000, 1'b1);
        mode_active_i <= 8'hFF;
        event_i <= 8'h00;
        count_event_i <= 1'b1;
        cy(20);
        count_event_i <= 1'b0;
        h.restart(16'h0004);
        cy(6);
        h.acc(1'b0, 9'h01A, 16'h0000, 16'h000F, 1'b1);
        h.acc(1'b0, 9'h014, 16'h0000, 16'h0002, 1'b1);
        mode_active_i <= 8'hFE;
        count_event_i <= 1'b1;
        cy(5);
        count_event_i <= 1'b0;
        h.restart(16'h0004);
        cy(6);
        h.acc(1'b0, 9'h01A, 16'h0000, 16'h0000, 1'b1);
        mode_active_i <= 8'hFF;
        event_i <= 8'h04;
        cy(3);
        datapath_reset_n_i <= 1'b0;
        h.acc(1'b1, 9'h004, ~r, 16'h0000, 1'b1);
        cy(3);
        check(cr2_o, r & M2);
        check({15'h0000, irq_o}, 16'h0000);
        h.acc(1'b0, 9'h004, 16'h0000, ~r & M2, 1'b1);
        datapath_reset_n_i <= 1'b1;
        event_i <= 8'h00;
        cy(2);
        check(cr2_o, ~r & M2);
        h.acc(1'b0, 9'h016, 16'h0000, 16'h0000, 1'b1);
        drain();
        finish_test();
    end
endmodule // rmcl_top_bench
bind rmcl_top rmcl_checker #(.CNT_W(CNT_W), .ID_VALUE(ID_VALUE)) chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .datapath_reset_n_i(datapath_reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .rd_i(rd_i), .wr_i(wr_i),
    .rdata_o(rdata_o), .ready_n_o(ready_n_o), .cr2_o(cr2_o), .pin_ctrl_o(pin_ctrl_o),
    .zero_count_n_o(zero_count_n_o), .irq_o(irq_o));
